// *** src/cswc_top.sv ***
// Sleep and wake control for a radio: registers, timers and the wake sequencer
// Notes on behaviour
// (R1) Force command makes the next transmission start with a wake-up initializer.
// (R2) Force command acts at once; no save step is needed.
// (R3) Idle threshold in 100 ms ticks, 0 to 0xFFFF, counts quiet time.
// (R4) Idle threshold all ones: never add an initializer.
// (R5) Idle threshold elapsed: next transmission gets an initializer first.
// (R6) Host should set idle threshold below the wake-time timeout.
// (R7) Cyclic sleep after both timers elapse; wake once per interval to listen.
// (R8) Initializer seen while awake: receive only after it has finished.
// (R9) No initializer in the listen window: sleep again and keep cycling.
// (R10) Initializer length in ticks, 0 to 0xFF, reset 1.
// (R11) Sleeping receiver stays awake only after 35 ms of initializer.
// (R12) Host should make initializer longer than the sleep interval.
// (R13) Pin wake on: sleep input low keeps the device awake.
// (R14) After sleep input rises, stay up for the timeout, then sleep if idle.
// (R15) Pin wake only counts under a cyclic sleep mode.
// (R16) Mode codes: 0 off, 1 pin, 3 to 8 cyclic 0.5 to 16 s.
// (R17) Mode resets to 0: always active.
// (R18) Wake-time timeout in ticks, 0x10 to 0xFFFF, reset 0x64.
// (R19) Wake-time timeout applies only in cyclic or pin sleep modes; the code uses it in cyclic modes only, and pin mode sleeps on the pin alone.
// (R20) Synchronise within 35 ms; transmit within 50 ms of cold start.
// (R21) Timers use a shared 100 ms tick and restart on traffic.
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "cswc_regs.svh"
module cswc_top
   import cswc_pkg::*;
#(
   parameter int TICK_CYC = `CSWC_TICK_MS * `CSWC_CLK_KHZ,
   parameter int DET_CYC  = `CSWC_DET_MS * `CSWC_CLK_KHZ,
   parameter int COLD_CYC = `CSWC_COLD_MS * `CSWC_CLK_KHZ
) (
   // Clock, reset, enable
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   input  wire logic        ce,
   // Register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata_ff,
   // Sleep pin (asynchronous)
   input  wire logic        sleep_pin,
   // Modem side
   input  wire logic        serial_act,
   input  wire logic        rf_act,
   input  wire logic        tx_req,
   input  wire logic        init_detect,
   output logic             awake_ff,
   output logic             rx_en_ff,
   output logic             send_init_ff,
   output logic             tx_go_ff,
   output logic             tx_ready_ff
);
   // ==========================================
   // Configuration registers
   logic [3:0]  sleep_mode_select_ff;
   logic [15:0] idle_before_init_ff;
   logic [7:0]  init_duration_ff;
   logic        pin_wake_enable_ff;
   logic [15:0] wake_time_timeout_ff;

   // Write decode
   logic wr_mode;
   logic wr_idle;
   logic wr_dur;
   logic wr_pin;
   logic wr_wake;
   logic force_init_cmd;
   logic mode_legal;
   logic [15:0] wake_wr_val;

   assign wr_mode  = reg_wr && (reg_addr == `CSWC_A_MODE);
   assign wr_idle  = reg_wr && (reg_addr == `CSWC_A_IDLE);
   assign wr_dur   = reg_wr && (reg_addr == `CSWC_A_INITDUR);
   assign wr_pin   = reg_wr && (reg_addr == `CSWC_A_PINWAKE);
   assign wr_wake  = reg_wr && (reg_addr == `CSWC_A_WAKETO);
   assign force_init_cmd = reg_wr && (reg_addr == `CSWC_A_CMD)
                           && reg_wdata[`CSWC_CMD_FORCE];      // R1 R2
   // Illegal mode codes (2, above 8) are ignored
   assign mode_legal = (reg_wdata[31:4] == 28'h0000000)
                       && (reg_wdata[3:0] <= `CSWC_MAX_MODE)
                       && (reg_wdata[3:0] != 4'h2);            // R16
   // Timeout below its floor is raised to the floor
   assign wake_wr_val = (reg_wdata[15:0] < `CSWC_MIN_WAKETO) ?
                        `CSWC_MIN_WAKETO : reg_wdata[15:0];    // R18

   // Store configuration
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         sleep_mode_select_ff <= `CSWC_RST_MODE;              // R17
         idle_before_init_ff  <= `CSWC_RST_IDLE;              // R3
         init_duration_ff     <= `CSWC_RST_INITDUR;           // R10
         pin_wake_enable_ff   <= `CSWC_RST_PINWAKE;
         wake_time_timeout_ff <= `CSWC_RST_WAKETO;            // R18
      end else if (ce) begin
         if (wr_mode && mode_legal) begin
            sleep_mode_select_ff <= reg_wdata[3:0];
         end
         if (wr_idle) begin
            idle_before_init_ff <= reg_wdata[15:0];           // R3
         end
         if (wr_dur) begin
            init_duration_ff <= reg_wdata[7:0];               // R10
         end
         if (wr_pin) begin
            pin_wake_enable_ff <= reg_wdata[0];
         end
         if (wr_wake) begin
            wake_time_timeout_ff <= wake_wr_val;
         end
      end
   end

   // ==========================================
   // Sleep pin synchroniser
   logic pin_s1_ff;
   logic pin_s2_ff;

   // Two stages before any logic looks at the pin
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         pin_s1_ff <= 1'b0;
         pin_s2_ff <= 1'b0;
      end else if (ce) begin
         pin_s1_ff <= sleep_pin;
         pin_s2_ff <= pin_s1_ff;
      end
   end

   // ==========================================
   // Shared 100 ms tick
   logic tick;

   cswc_tick #(
      .TICK_CYC (TICK_CYC)
   ) u_tick (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .ce      (ce),
      .tick_ff (tick)                                         // R21
   );

   // ==========================================
   // Mode decode
   cswc_state_t state_ff;
   cswc_state_t nxt_state;
   logic        is_cyclic;
   logic        is_pinmode;
   logic        pin_hold;
   logic [7:0]  slp_ticks;

   assign is_cyclic  = (sleep_mode_select_ff >= `CSWC_MODE_CYC0)
                       && (sleep_mode_select_ff <= `CSWC_MAX_MODE);
   assign is_pinmode = (sleep_mode_select_ff == `CSWC_MODE_PIN);
   // Low pin keeps a cyclic sleeper awake
   assign pin_hold   = pin_wake_enable_ff && is_cyclic && !pin_s2_ff; // R13 R15

   // Wake period for each cyclic mode
   assign slp_ticks =
      (sleep_mode_select_ff == 4'h3) ? `CSWC_SLP_M3 :
      (sleep_mode_select_ff == 4'h4) ? `CSWC_SLP_M4 :
      (sleep_mode_select_ff == 4'h5) ? `CSWC_SLP_M5 :
      (sleep_mode_select_ff == 4'h6) ? `CSWC_SLP_M6 :
      (sleep_mode_select_ff == 4'h7) ? `CSWC_SLP_M7 :
                                       `CSWC_SLP_M8;         // R16

   // ==========================================
   // Inactivity timer
   logic [15:0] idle_ff;
   logic        traffic;
   logic        idle_hit;
   logic        wake_hit;
   logic        init_never;

   assign traffic = serial_act || rf_act || tx_go_ff || pin_hold
                    || (state_ff == CSWC_INITTX)
                    || (state_ff == CSWC_RXWAIT);             // R21 R14
   assign init_never = (idle_before_init_ff == `CSWC_IDLE_NEVER); // R4
   assign idle_hit = !init_never && (idle_ff >= idle_before_init_ff); // R3
   assign wake_hit = (idle_ff >= wake_time_timeout_ff);       // R18

   // Count quiet ticks, saturating, cleared by traffic
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         idle_ff <= 16'h0000;
      end else if (ce) begin
         if (traffic) begin
            idle_ff <= 16'h0000;                              // R21
         end else if (tick && idle_ff != 16'hFFFF) begin
            idle_ff <= idle_ff + 16'h0001;
         end
      end
   end

   // ==========================================
   // Initializer request flag
   logic init_pend_ff;
   logic pend_set;
   logic pend_clr;

   assign pend_set = force_init_cmd || idle_hit;              // R1 R5
   assign pend_clr = tx_go_ff;

   // Setting wins over clearing in the same cycle
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         init_pend_ff <= 1'b0;
      end else if (ce) begin
         if (pend_set) begin
            init_pend_ff <= 1'b1;
         end else if (pend_clr) begin
            init_pend_ff <= 1'b0;
         end
      end
   end

   // ==========================================
   // Sequencer counters
   logic [22:0] cyc_ff;
   logic [7:0]  tk_ff;
   logic        cold_done;
   logic        det_done;
   logic        sleep_ok;
   logic        wake_evt;
   logic        use_init;

   assign cold_done = (cyc_ff == 23'(COLD_CYC - 1));          // R20
   assign det_done  = init_detect && (cyc_ff == 23'(DET_CYC - 1)); // R11 R20
   assign sleep_ok  = !tx_req && !pin_hold
                      && ((is_cyclic && wake_hit
                           && (idle_hit || init_never))       // R7 R19 R14
                          || (is_pinmode && pin_s2_ff));
   assign wake_evt  = serial_act || tx_req
                      || (is_pinmode && !pin_s2_ff) || pin_hold;
   assign use_init  = init_pend_ff && (init_duration_ff != 8'h00);

   // ==========================================
   // Next state
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         CSWC_COLD: begin
            if (cold_done) begin
               nxt_state = CSWC_AWAKE;
            end
         end
         CSWC_AWAKE: begin
            if (tx_req && !tx_go_ff && use_init) begin
               nxt_state = CSWC_INITTX;                       // R1 R5
            end else if (init_detect) begin
               nxt_state = CSWC_RXWAIT;                       // R8
            end else if (sleep_ok) begin
               nxt_state = CSWC_SLEEP;                        // R7
            end
         end
         CSWC_INITTX: begin
            if (tick && tk_ff == init_duration_ff - 8'h01) begin
               nxt_state = CSWC_AWAKE;                        // R10
            end
         end
         CSWC_RXWAIT: begin
            if (!init_detect) begin
               nxt_state = CSWC_AWAKE;                        // R8
            end
         end
         CSWC_SLEEP: begin
            if (wake_evt) begin
               nxt_state = CSWC_AWAKE;
            end else if (is_cyclic && tick && tk_ff == slp_ticks - 8'h01) begin
               nxt_state = CSWC_LISTEN;                       // R7
            end
         end
         CSWC_LISTEN: begin
            if (wake_evt) begin
               nxt_state = CSWC_AWAKE;
            end else if (det_done) begin
               nxt_state = CSWC_RXWAIT;                       // R11
            end else if (tick) begin
               nxt_state = CSWC_SLEEP;                        // R9
            end
         end
         default: begin
            nxt_state = CSWC_COLD;
         end
      endcase
   end

   // ==========================================
   // Counter updates: cycles in cold start and listen, ticks elsewhere
   logic [22:0] nxt_cyc;
   logic [7:0]  nxt_tk;
   logic        st_chg;

   assign st_chg  = (nxt_state != state_ff);
   assign nxt_cyc = (st_chg || (state_ff == CSWC_LISTEN && !init_detect)) ?
                    23'h000000 : cyc_ff + 23'h000001;
   assign nxt_tk  = st_chg ? 8'h00 : (tick ? tk_ff + 8'h01 : tk_ff);

   // State and counters
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         state_ff <= CSWC_COLD;
         cyc_ff   <= 23'h000000;
         tk_ff    <= 8'h00;
      end else if (ce) begin
         state_ff <= nxt_state;
         cyc_ff   <= nxt_cyc;
         tk_ff    <= nxt_tk;
      end
   end

   // ==========================================
   // Modem outputs
   logic nxt_go;

   // Start data when asked: straight away, or after the initializer
   assign nxt_go = (state_ff == CSWC_AWAKE && tx_req && !tx_go_ff && !use_init)
                   || (state_ff == CSWC_INITTX && nxt_state == CSWC_AWAKE);

   // Registered control outputs
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         awake_ff     <= 1'b1;
         rx_en_ff     <= 1'b0;
         send_init_ff <= 1'b0;
         tx_go_ff     <= 1'b0;
         tx_ready_ff  <= 1'b0;
      end else if (ce) begin
         awake_ff     <= (nxt_state != CSWC_SLEEP);           // R7
         rx_en_ff     <= (nxt_state == CSWC_AWAKE);           // R8
         send_init_ff <= (nxt_state == CSWC_INITTX);          // R1 R10
         tx_go_ff     <= nxt_go;
         if (state_ff == CSWC_COLD && cold_done) begin
            tx_ready_ff <= 1'b1;                              // R20
         end
      end
   end

   // ==========================================
   // Read back
   logic [31:0] status;
   logic [31:0] rd_mux;

   assign status = {18'h00000, state_ff, 4'h0, pin_s2_ff, tx_ready_ff,
                    init_pend_ff, awake_ff};
   assign rd_mux =
      (reg_addr == `CSWC_A_MODE)    ? {28'h0000000, sleep_mode_select_ff} :
      (reg_addr == `CSWC_A_IDLE)    ? {16'h0000, idle_before_init_ff} :
      (reg_addr == `CSWC_A_INITDUR) ? {24'h000000, init_duration_ff} :
      (reg_addr == `CSWC_A_PINWAKE) ? {31'h00000000, pin_wake_enable_ff} :
      (reg_addr == `CSWC_A_WAKETO)  ? {16'h0000, wake_time_timeout_ff} :
      (reg_addr == `CSWC_A_STATUS)  ? status :
                                      32'h00000000;

   // Read data stand for the cycle after the strobe only
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         reg_rdata_ff <= 32'h00000000;
      end else if (ce) begin
         reg_rdata_ff <= reg_rd ? rd_mux : 32'h00000000;
      end
   end
endmodule

// *** src/cswc_regs.svh ***
// Register offsets, reset values and timing figures of the sleep and wake control
`ifndef CSWC_REGS_SVH
`define CSWC_REGS_SVH
// ==========================================
// Register offsets (byte addresses)
`define CSWC_A_MODE      8'h00
`define CSWC_A_IDLE      8'h04
`define CSWC_A_INITDUR   8'h08
`define CSWC_A_PINWAKE   8'h0C
`define CSWC_A_WAKETO    8'h10
`define CSWC_A_CMD       8'h14
`define CSWC_A_STATUS    8'h18
// ==========================================
// Reset values and ranges
`define CSWC_RST_MODE    4'h0
`define CSWC_RST_IDLE    16'hFFFF
`define CSWC_IDLE_NEVER  16'hFFFF
`define CSWC_RST_INITDUR 8'h01
`define CSWC_RST_PINWAKE 1'b0
`define CSWC_RST_WAKETO  16'h0064
`define CSWC_MIN_WAKETO  16'h0010
`define CSWC_MAX_MODE    4'h8
`define CSWC_MODE_OFF    4'h0
`define CSWC_MODE_PIN    4'h1
`define CSWC_MODE_CYC0   4'h3
// ==========================================
// Field positions
`define CSWC_CMD_FORCE   0
`define CSWC_ST_AWAKE    0
`define CSWC_ST_PEND     1
`define CSWC_ST_READY    2
`define CSWC_ST_PIN      3
`define CSWC_ST_STATE    8
// ==========================================
// Cyclic wake periods in 100 ms ticks (modes 3 to 8)
`define CSWC_SLP_M3      8'h05
`define CSWC_SLP_M4      8'h0A
`define CSWC_SLP_M5      8'h14
`define CSWC_SLP_M6      8'h28
`define CSWC_SLP_M7      8'h50
`define CSWC_SLP_M8      8'hA0
// ==========================================
// Timing: clock rate and times in their own units
`define CSWC_CLK_KHZ     125000
`define CSWC_TICK_MS     100
`define CSWC_DET_MS      35
`define CSWC_COLD_MS     50
`endif

// *** src/cswc_pkg.sv ***
// Types shared by the sleep and wake control
package cswc_pkg;
   // ==========================================
   // Control states, one-hot
   typedef enum logic [5:0] {
      CSWC_COLD   = 6'h01,
      CSWC_AWAKE  = 6'h02,
      CSWC_INITTX = 6'h04,
      CSWC_RXWAIT = 6'h08,
      CSWC_SLEEP  = 6'h10,
      CSWC_LISTEN = 6'h20
   } cswc_state_t;
endpackage

// *** src/cswc_tick.sv ***
// Free running 100 ms tick generator
`timescale 1ns/1ps
module cswc_tick #(
   parameter int TICK_CYC = 12500000
) (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rstn,
   input  wire logic ce,
   // Tick out
   output logic      tick_ff
);
   // ==========================================
   // Divider
   logic [23:0] cnt_ff;
   logic [23:0] nxt_cnt;
   logic        wrap;

   assign wrap    = (cnt_ff == 24'(TICK_CYC - 1));
   assign nxt_cnt = wrap ? 24'h000000 : cnt_ff + 24'h000001;

   // Count cycles and pulse once per period
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         cnt_ff  <= 24'h000000;
         tick_ff <= 1'b0;
      end else if (ce) begin
         cnt_ff  <= nxt_cnt;
         tick_ff <= wrap;
      end
   end
endmodule

// *** testbench/cswc_remote_model.sv ***
// Remote radio sending one wake-up initializer burst on request
`timescale 1ns/1ps
module cswc_remote_model #(
   parameter int BURST_CYC = 140
) (
   // Clock
   input  wire logic ref_clk,
   // Request from the bench
   input  wire logic start,
   // Initializer as heard by the modem
   output logic      init_detect
);
   int left_ff = 0;
   // ====
   // Burst counter, longer than the receiver sleep interval
   always @(posedge ref_clk) begin
      if (start)
         left_ff <= BURST_CYC;
      else if (left_ff > 0)
         left_ff <= left_ff - 1;
   end
   assign init_detect = (left_ff > 0);
endmodule

// *** testbench/cswc_properties.sv ***
// Port checks of the sleep and wake control
`timescale 1ns/1ps
`include "cswc_regs.svh"
module cswc_properties #(
   parameter int COLD_CYC = 8
) (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   input  wire logic        ce,
   // Register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_rd,
   input  wire logic [31:0] reg_rdata_ff,
   // Modem side
   input  wire logic        tx_req,
   input  wire logic        init_detect,
   input  wire logic        awake_ff,
   input  wire logic        rx_en_ff,
   input  wire logic        send_init_ff,
   input  wire logic        tx_go_ff,
   input  wire logic        tx_ready_ff
);
   int cnt_ff;
   // ====
   // Enabled cycles since reset release, held once past the cold start
   always_ff @(posedge ref_clk) begin
      if (!rstn)
         cnt_ff <= 0;
      else if (ce && cnt_ff <= COLD_CYC)
         cnt_ff <= cnt_ff + 1;
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // ====
   // Output relations
   property p_reset;
      $rose(rstn) |-> awake_ff && !rx_en_ff && !send_init_ff && !tx_go_ff && !tx_ready_ff;
   endproperty
   a_reset: assert property (p_reset) else $error("outputs not at reset values");
   property p_ready;
      $rose(tx_ready_ff) |-> cnt_ff >= COLD_CYC - 1 && cnt_ff <= COLD_CYC + 1;
   endproperty
   a_ready: assert property (p_ready) else $error("cold start length wrong");
   property p_sticky;
      tx_ready_ff |=> tx_ready_ff;
   endproperty
   a_sticky: assert property (p_sticky) else $error("ready flag dropped");
   property p_gopulse;
      tx_go_ff |=> !tx_go_ff;
   endproperty
   a_gopulse: assert property (p_gopulse) else $error("transmit start longer than one cycle");
   property p_goreq;
      tx_go_ff |-> $past(tx_req);
   endproperty
   a_goreq: assert property (p_goreq) else $error("transmit start without request");
   property p_initend;
      $fell(send_init_ff) |-> tx_go_ff;
   endproperty
   a_initend: assert property (p_initend) else $error("initializer end without transmit");
   property p_rx;
      $rose(rx_en_ff) |-> !$past(init_detect);
   endproperty
   a_rx: assert property (p_rx) else $error("receive during initializer");
   property p_sleep;
      !awake_ff |-> !rx_en_ff && !send_init_ff;
   endproperty
   a_sleep: assert property (p_sleep) else $error("activity while asleep");
   property p_mode;
      reg_rd && reg_addr == `CSWC_A_MODE |=> reg_rdata_ff <= 32'h8 && reg_rdata_ff != 32'h2;
   endproperty
   a_mode: assert property (p_mode) else $error("illegal sleep mode read back");
   property p_wake;
      reg_rd && reg_addr == `CSWC_A_WAKETO |=> reg_rdata_ff >= 32'h10 && reg_rdata_ff <= 32'hFFFF;
   endproperty
   a_wake: assert property (p_wake) else $error("wake timeout out of range");
endmodule
bind cswc_top cswc_properties #(.COLD_CYC(COLD_CYC)) u_cswc_properties (.ref_clk(ref_clk), .rstn(rstn), .ce(ce),
   .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .tx_req(tx_req),
   .init_detect(init_detect), .awake_ff(awake_ff), .rx_en_ff(rx_en_ff), .send_init_ff(send_init_ff),
   .tx_go_ff(tx_go_ff), .tx_ready_ff(tx_ready_ff));

// *** testbench/cswc_top_bench.sv ***
// Self-checking bench of the sleep and wake control
`timescale 1ns/1ps
`include "cswc_regs.svh"
module cswc_top_bench;
   typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;} cswc_row_t;
   logic        ref_clk, rstn, ce, reg_wr, reg_rd, sleep_pin, serial_act, rf_act, tx_req, init_go;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata_ff, q;
   logic        awake_ff, rx_en_ff, send_init_ff, tx_go_ff, tx_ready_ff, init_detect;
   logic [3:0]  mon;
   int          mismatches, compares, cyc, ni, nc;
   cswc_row_t   rows [9];
   assign mon = {tx_ready_ff, send_init_ff, rx_en_ff, awake_ff};
   // ====
   // Design and remote radio
   cswc_top #(.TICK_CYC(20), .DET_CYC(5), .COLD_CYC(8)) u_cswc_top (.ref_clk(ref_clk), .rstn(rstn),
      .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata_ff(reg_rdata_ff), .sleep_pin(sleep_pin), .serial_act(serial_act), .rf_act(rf_act),
      .tx_req(tx_req), .init_detect(init_detect), .awake_ff(awake_ff), .rx_en_ff(rx_en_ff),
      .send_init_ff(send_init_ff), .tx_go_ff(tx_go_ff), .tx_ready_ff(tx_ready_ff));
   cswc_remote_model u_cswc_remote_model (.ref_clk(ref_clk), .start(init_go), .init_detect(init_detect));
   // ====
   // Clock and hang guard
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         mismatches++;
         end_sim();
      end
   end
   // ====
   // Tasks
   task end_sim();
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task cmp(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      q = reg_rdata_ff;
   endtask
   // Wait bounded for one output to reach a level, then check it
   task wt(input int s, input logic v, input int lim);
      int n;
      n = 0;
      while (mon[s] !== v && n < lim) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      cmp({31'h0, mon[s]}, {31'h0, v});
   endtask
   // Request a transmission; count initializer cycles and cycles to start
   task send();
      ni = 0;
      nc = 0;
      @(posedge ref_clk);
      tx_req <= 1'b1;
      do begin
         @(posedge ref_clk);
         #1;
         ni += send_init_ff;
         nc++;
      end while (tx_go_ff !== 1'b1 && nc < 200);
      @(posedge ref_clk);
      tx_req <= 1'b0;
   endtask
   task pin(input logic v);
      @(posedge ref_clk);
      sleep_pin <= v;
   endtask
   // ====
   // Main sequence
   initial begin
      {rstn, reg_wr, reg_rd, sleep_pin, serial_act, rf_act, tx_req, init_go} = 8'h00;
      {ce, reg_addr, reg_wdata, mismatches, compares, cyc} = 0;
      ce = 1'b1;
      rows[0] = '{`CSWC_A_MODE, 1'b0, 32'h0, 32'h0};
      rows[1] = '{`CSWC_A_IDLE, 1'b0, 32'h0, 32'h0000FFFF};
      rows[2] = '{`CSWC_A_INITDUR, 1'b0, 32'h0, 32'h1};
      rows[3] = '{`CSWC_A_WAKETO, 1'b0, 32'h0, 32'h64};
      rows[4] = '{`CSWC_A_WAKETO, 1'b1, 32'h5, 32'h10};
      rows[5] = '{`CSWC_A_IDLE, 1'b1, 32'hFFFF, 32'h0000FFFF};
      rows[6] = '{`CSWC_A_INITDUR, 1'b1, 32'hFF, 32'hFF};
      rows[7] = '{`CSWC_A_CMD, 1'b0, 32'h0, 32'h0};
      rows[8] = '{8'h1C, 1'b1, 32'h5A, 32'h0};
      repeat (10) @(posedge ref_clk);
      rstn <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].w)
            wr(rows[i].a, rows[i].d);
         rd(rows[i].a);
         cmp(q, rows[i].e);
      end
      wt(3, 1'b1, 20);
      for (int m = 0; m < 9; m++) begin
         wr(`CSWC_A_MODE, m);
         rd(`CSWC_A_MODE);
         cmp(q, (m == 2) ? 1 : m);
      end
      wr(`CSWC_A_MODE, 0);
      send();
      cmp(nc, 1);
      cmp(ni, 0);
      wr(`CSWC_A_INITDUR, 2);
      wr(`CSWC_A_CMD, 1);
      rd(`CSWC_A_STATUS);
      cmp(q, 32'h00000207);
      send();
      cmp(ni > 20 && ni <= 40, 1);
      wr(`CSWC_A_IDLE, 2);
      repeat (70) @(posedge ref_clk);
      send();
      cmp(ni > 20, 1);
      // Each quiet gap holds at most one tick; without restarts two would pass
      repeat (17) @(posedge ref_clk);
      serial_act <= 1'b1;
      @(posedge ref_clk);
      serial_act <= 1'b0;
      rf_act <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rf_act <= 1'b0;
      repeat (19) @(posedge ref_clk);
      send();
      cmp(ni, 0);
      // Cyclic sleep, listen, miss, then a long initializer
      wr(`CSWC_A_MODE, 3);
      wt(0, 1'b0, 400);
      wt(0, 1'b1, 125);
      wt(0, 1'b0, 25);
      @(posedge ref_clk);
      init_go <= 1'b1;
      @(posedge ref_clk);
      init_go <= 1'b0;
      wt(1, 1'b1, 300);
      cmp(awake_ff, 1'b1);
      // Sleep pin holds the radio awake, then releases it
      wr(`CSWC_A_PINWAKE, 1);
      repeat (400) @(posedge ref_clk);
      #1;
      cmp(awake_ff, 1'b1);
      pin(1'b1);
      wt(0, 1'b0, 400);
      pin(1'b0);
      wt(0, 1'b1, 30);
      wr(`CSWC_A_MODE, 1);
      pin(1'b1);
      wt(0, 1'b0, 30);
      pin(1'b0);
      wt(0, 1'b1, 30);
      // Reset in mid-run
      @(posedge ref_clk);
      rstn <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rstn <= 1'b1;
      rd(`CSWC_A_MODE);
      cmp(q, 0);
      // Enable low freezes the cold start count
      @(posedge ref_clk);
      ce <= 1'b0;
      repeat (20) @(posedge ref_clk);
      cmp(tx_ready_ff, 1'b0);
      ce <= 1'b1;
      wt(3, 1'b1, 20);
      end_sim();
   end
endmodule
